/* File: logic/sac_pkg.sv */
`default_nettype none
package sac_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h34;
    localparam logic [7:0] OFS_RESULT = 8'h35;
    localparam logic [7:0] OFS_AMP_CLOCK = 8'h36;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h39;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h3A;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CSR_DONE_BIT = 7;
    localparam int CSR_SPEED_BIT = 6;
    localparam int CSR_POWER_BIT = 5;
    localparam int AMP_SLOW_BIT = 3;
    localparam int AMP_GAIN_BIT = 2;
    localparam logic [7:0] AMP_WRITE_MASK = 8'h0C;
    localparam logic [7:0] CSR_WRITE_MASK = 8'h67;

    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam logic [7:0] RESET_CTRL_STATUS = 8'h00;
    localparam logic [7:0] RESET_RESULT = 8'h00;
    localparam logic [7:0] RESET_AMP_CLOCK = 8'h00;
    localparam logic [7:0] RESULT_FULL_SCALE = 8'hFF;
    localparam logic [7:0] RESULT_ZERO_SCALE = 8'h00;
    localparam int APPROX_STEPS = 8;
    localparam int GAIN_FACTOR = 8;
    localparam int SAMPLE_CYCLES_DEFAULT = 4;
    localparam int SETTLE_CYCLES = 3;
    localparam logic [1:0] DIV_HALF = 2'd1;
    localparam logic [1:0] DIV_QUARTER = 2'd3;

    typedef enum logic [1:0] {
        SAC_OFF,
        SAC_SAMPLE,
        SAC_HOLD
    } sac_phase_type;

endpackage
`default_nettype wire

/* File: logic/sac_adc_control.sv */
`timescale 1ns/1ps
`default_nettype none

module sac_adc_control #(
    parameter int SAMPLE_CYCLES = sac_pkg::SAMPLE_CYCLES_DEFAULT
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic comparator_out,
    output logic converter_enable,
    output logic gain_stage_enable,
    output logic sample_connect,
    output logic [2:0] input_channel_select,
    output logic [7:0] dac_trial,
    output logic irq
);

    // ----------------------------------------
    // Reset release and comparator synchroniser
    // ----------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    logic cmp_s1_r;
    logic cmp_s2_r;
    logic cmp_s3_r;

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            cmp_s3_r <= 1'b0;
        end else begin
            cmp_s1_r <= comparator_out;
            cmp_s2_r <= cmp_s1_r;
            cmp_s3_r <= cmp_s2_r;
        end
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] control_status_register;
        logic [7:0] result;
        logic [7:0] amp;
        logic [7:0] irq_stat;
        logic [7:0] irq_en;
        logic [7:0] rdata;
        sac_pkg::sac_phase_type phase;
        logic [1:0] div_cnt;
        logic [7:0] samp_cnt;
        logic [3:0] step;
        logic [7:0] trial;
        logic [7:0] bitmask;
        logic cmp_q;
        logic [1:0] settle;
        logic conv_en;
        logic gain_en;
        logic connect;
        logic irq;
    } sac_state_type;

    sac_state_type st_r;
    sac_state_type st_nxt;

    logic csr_wr;
    logic res_rd;
    logic running;
    logic tick;
    logic cmp_now;
    logic [7:0] kept;
    logic done_evt;

    always_comb begin
        st_nxt = st_r;
        done_evt = 1'b0;
        csr_wr = reg_write && (reg_addr == sac_pkg::OFS_CTRL_STATUS);
        res_rd = reg_read && (reg_addr == sac_pkg::OFS_RESULT);
        // Halt stops conversions, wait has no effect
        running = st_r.control_status_register[sac_pkg::CSR_POWER_BIT] && !halt_mode;
        cmp_now = (cmp_s2_r == cmp_s3_r) ? cmp_s3_r : st_r.cmp_q;
        st_nxt.cmp_q = cmp_now;
        kept = 8'h00;
        // Cycles since the trial level last moved, saturating
        if (st_r.settle != 2'(sac_pkg::SETTLE_CYCLES)) begin
            st_nxt.settle = st_r.settle + 2'd1;
        end

        // Conversion clock enable from slow and speed bits
        if (st_r.amp[sac_pkg::AMP_SLOW_BIT]) begin
            tick = (st_r.div_cnt == sac_pkg::DIV_QUARTER);
        end else if (st_r.control_status_register[sac_pkg::CSR_SPEED_BIT]) begin
            tick = 1'b1;
        end else begin
            tick = st_r.div_cnt[0] == sac_pkg::DIV_HALF[0];
        end
        st_nxt.div_cnt = st_r.div_cnt + 2'd1;

        // Register writes
        if (reg_write) begin
            unique case (reg_addr)
                sac_pkg::OFS_CTRL_STATUS: begin
                    st_nxt.control_status_register = reg_wdata & sac_pkg::CSR_WRITE_MASK;
                end
                sac_pkg::OFS_AMP_CLOCK: begin
                    st_nxt.amp = reg_wdata & sac_pkg::AMP_WRITE_MASK;
                end
                sac_pkg::OFS_IRQ_ENABLE: begin
                    st_nxt.irq_en = reg_wdata;
                end
                sac_pkg::OFS_IRQ_CLEAR: begin
                    st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata;
                end
                default: begin
                end
            endcase
        end
        if (res_rd) begin
            st_nxt.control_status_register[sac_pkg::CSR_DONE_BIT] = 1'b0;
        end

        // Sequencer
        if (!running) begin
            st_nxt.phase = sac_pkg::SAC_OFF;
        end else if (csr_wr || st_r.phase == sac_pkg::SAC_OFF) begin
            // Restart on power-up or any control write
            st_nxt.phase = sac_pkg::SAC_SAMPLE;
            st_nxt.samp_cnt = 8'd0;
            st_nxt.div_cnt = 2'd0;
        end else if (tick) begin
            unique case (st_r.phase)
                sac_pkg::SAC_SAMPLE: begin
                    if (st_r.samp_cnt == 8'(SAMPLE_CYCLES - 1)) begin
                        st_nxt.phase = sac_pkg::SAC_HOLD;
                        st_nxt.step = 4'd0;
                        st_nxt.bitmask = 8'h80;
                        st_nxt.trial = 8'h80;
                        st_nxt.settle = 2'd0;
                    end else begin
                        st_nxt.samp_cnt = st_r.samp_cnt + 8'd1;
                    end
                end
                sac_pkg::SAC_HOLD: begin
                    // Step only once the comparator has crossed the synchroniser
                    // Faster clocks therefore stretch the hold phase
                    if (st_r.settle == 2'(sac_pkg::SETTLE_CYCLES)) begin
                        // Keep bit when input is above trial level
                        kept = cmp_now ? st_r.trial : (st_r.trial & ~st_r.bitmask);
                        st_nxt.bitmask = st_r.bitmask >> 1;
                        st_nxt.trial = kept | (st_r.bitmask >> 1);
                        st_nxt.step = st_r.step + 4'd1;
                        st_nxt.settle = 2'd0;
                        if (st_r.step == 4'(sac_pkg::APPROX_STEPS - 1)) begin
                            st_nxt.result = kept;
                            st_nxt.control_status_register[sac_pkg::CSR_DONE_BIT] = 1'b1;
                            done_evt = 1'b1;
                            st_nxt.phase = sac_pkg::SAC_SAMPLE;
                            st_nxt.samp_cnt = 8'd0;
                        end
                    end
                end
                default: begin
                    st_nxt.phase = sac_pkg::SAC_OFF;
                end
            endcase
        end

        // Sticky event bit: set wins over clear
        if (done_evt) begin
            st_nxt.irq_stat[0] = 1'b1;
        end

        // Outputs
        st_nxt.conv_en = running;
        st_nxt.gain_en = running && st_r.amp[sac_pkg::AMP_GAIN_BIT];
        st_nxt.connect = st_nxt.phase == sac_pkg::SAC_SAMPLE;
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);

        st_nxt.rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                sac_pkg::OFS_CTRL_STATUS: st_nxt.rdata = st_r.control_status_register;
                sac_pkg::OFS_RESULT: st_nxt.rdata = st_r.result;
                sac_pkg::OFS_AMP_CLOCK: st_nxt.rdata = st_r.amp;
                sac_pkg::OFS_IRQ_STATUS: st_nxt.rdata = st_r.irq_stat;
                sac_pkg::OFS_IRQ_ENABLE: st_nxt.rdata = st_r.irq_en;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign converter_enable = st_r.conv_en;
    assign gain_stage_enable = st_r.gain_en;
    assign sample_connect = st_r.connect;
    assign input_channel_select = st_r.control_status_register[2:0];
    assign dac_trial = st_r.trial;
    assign irq = st_r.irq;

endmodule // sac_adc_control
`default_nettype wire

/* File: sim/sac_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sac_far_model (
    input wire logic sample_connect,
    input wire logic gain_stage_enable,
    input wire logic [7:0] analog_in,
    input wire logic [7:0] dac_trial,
    output logic comparator_out
);
    logic [10:0] amp;
    logic [7:0] held;
    assign amp = gain_stage_enable ? {analog_in, 3'h0} : {3'h0, analog_in};
    // Capacitor tracks only while connected, clipped at full scale
    always_latch if (sample_connect) held = (amp > 11'h0ff) ? 8'hff : amp[7:0];
    // Input sits half a step above its code
    assign comparator_out = held >= dac_trial;
endmodule // sac_far_model
`default_nettype wire

/* File: sim/sac_adc_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sac_adc_control_props #(
    parameter int SAMPLE_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic halt_mode,
    input wire logic converter_enable,
    input wire logic gain_stage_enable,
    input wire logic sample_connect,
    input wire logic [2:0] input_channel_select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence csr_wr;
        reg_write && reg_addr == sac_pkg::OFS_CTRL_STATUS;
    endsequence
    sequence pwr_wr;
        csr_wr and (reg_wdata[5] && !halt_mode);
    endsequence
    sequence off_wr;
        csr_wr and !reg_wdata[5];
    endsequence
    sequence sample_start;
        $rose(sample_connect) && !halt_mode;
    endsequence
    property chan_follows;
        logic [2:0] ch;
        (csr_wr, ch = reg_wdata[2:0]) |=> input_channel_select == ch;
    endproperty
    a_chan_follows: assert property (chan_follows)
        else $error("channel select did not follow write");
    a_halt_stops: assert property (halt_mode [*3] |-> !converter_enable)
        else $error("converter on in halt");
    a_amp_zero: assert property (reg_read && reg_addr == sac_pkg::OFS_AMP_CLOCK |=>
        (reg_rdata & 8'hf3) == 8'h00) else $error("amplifier unused bits not zero");
    a_power_samples: assert property (pwr_wr |-> ##[1:3] sample_connect)
        else $error("no sample phase after power write");
    a_power_enable: assert property (pwr_wr |-> ##2 converter_enable)
        else $error("converter not enabled");
    a_power_off: assert property (off_wr |-> ##2 !converter_enable && !gain_stage_enable)
        else $error("converter or amplifier still on");
    a_gain_on: assert property (reg_write && reg_addr == sac_pkg::OFS_AMP_CLOCK &&
        reg_wdata[2] && converter_enable && !halt_mode |-> ##[1:2] gain_stage_enable)
        else $error("gain stage not on");
    a_sample_min: assert property (disable iff (!resetn || halt_mode || !converter_enable)
        sample_start |-> sample_connect [*4]) else $error("sample phase too short");
endmodule // sac_adc_control_props
bind sac_adc_control sac_adc_control_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
    sac_adc_control_props_i (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .halt_mode, .converter_enable, .gain_stage_enable, .sample_connect,
    .input_channel_select);
`default_nettype wire

/* File: sim/sac_adc_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sac_adc_control_tb_top;
    logic core_clk = 0, resetn = 0, reg_write = 0, reg_read = 0, halt_mode = 0, wait_mode = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, analog_in = 8'h00, reg_rdata, dac_trial;
    logic comparator_out, converter_enable, gain_stage_enable, sample_connect, irq, rd_pend = 0;
    logic [2:0] input_channel_select;
    logic [7:0] d, v, e;
    logic [31:0] seed = 32'h8105_6389;
    int fail_count = 0, num_checks = 0, cyc = 0, slen = 0, last_slen = 0;
    logic [15:0] notes[$];
`define CHK(n, x, s) begin num_checks++; if ((s) !== (x)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, x, s); end end
    sac_adc_control #(.SAMPLE_CYCLES(4)) sac_adc_control_i (.core_clk, .resetn, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .halt_mode, .wait_mode, .comparator_out,
        .converter_enable, .gain_stage_enable, .sample_connect, .input_channel_select,
        .dac_trial, .irq);
    sac_far_model sac_far_model_i (.sample_connect, .gain_stage_enable, .analog_in, .dac_trial,
        .comparator_out);
    initial forever #20 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        seed <= lfsr(seed);
        wait_mode <= seed[3];
        rd_pend <= reg_read;
        if (sample_connect) slen <= slen + 1;
        else if (slen != 0) begin last_slen <= slen; slen <= 0; end
        if (cyc > 20000) begin fail_count++; conclude(); end
    end
    always @(negedge core_clk) if (rd_pend && notes.size() > 0) begin
        `CHK("rdata", notes[0][15:8], reg_rdata & notes[0][7:0])
        void'(notes.pop_front());
    end
    task automatic bus(input logic rd, input logic [7:0] a, w, m);
        reg_read <= rd; reg_write <= !rd; reg_addr <= a; reg_wdata <= w;
        if (rd) notes.push_back({w & m, m});
        @(posedge core_clk);
        reg_read <= 0; reg_write <= 0;
        #1 d = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic await_done();
        repeat (80) begin bus(1, 8'h34, 8'h00, 8'h00); if (d[7] === 1'b1) return; end
        `CHK("done", 1'b1, 1'b0)
    endtask
    logic [7:0] vin[5] = '{8'hc3, 8'h5a, 8'h00, 8'h00, 8'h40};
    logic [7:0] ex[5] = '{8'hc3, 8'h5a, 8'h00, 8'h00, 8'hff};
    logic [7:0] amp[5] = '{8'h00, 8'h00, 8'h08, 8'h0c, 8'h0c};
    logic [7:0] control_status_register;
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1;
        repeat (3) @(posedge core_clk);
        foreach (vin[i]) bus(1, 8'h34 + 8'(i + i / 3 * 2), 8'h00, 8'hff);
        bus(0, 8'h36, 8'hff, 0);
        bus(1, 8'h36, 8'h0c, 8'hff);
        bus(0, 8'h39, 8'h01, 0);
        for (int i = 0; i < 5; i++) begin
            v = i == 2 ? seed[7:0] : vin[i];
            e = i == 2 ? v : ex[i];
            analog_in <= v;
            control_status_register = {1'b0, i == 1, 1'b1, 2'b00, 3'(i)};
            bus(0, 8'h36, amp[i], 0);
            bus(0, 8'h34, control_status_register, 0);
            `CHK("chan", 3'(i), input_channel_select)
            await_done();
            bus(1, 8'h35, 8'h00, 8'h00);
            await_done();
            bus(1, 8'h35, e, 8'hff);
            bus(1, 8'h34, 8'h00, 8'h80);
            await_done();
            `CHK("sample len", 4 * (amp[i][3] ? 4 : (i == 1 ? 1 : 2)), last_slen)
            bus(0, 8'h34, control_status_register, 0);
            bus(1, 8'h34, control_status_register, 8'hff);
            $display("case %0d done", i);
        end
        `CHK("irq", 1'b1, irq)
        bus(0, 8'h39, 8'h00, 0);
        `CHK("masked", 1'b0, irq)
        halt_mode <= 1;
        repeat (4) @(posedge core_clk);
        `CHK("halt", 1'b0, converter_enable)
        halt_mode <= 0;
        bus(0, 8'h34, 8'h00, 0);
        @(posedge core_clk);
        `CHK("off", 1'b0, converter_enable | gain_stage_enable)
        bus(0, 8'h3a, 8'h01, 0);
        bus(0, 8'h39, 8'h01, 0);
        bus(1, 8'h38, 8'h00, 8'hff);
        `CHK("cleared", 1'b0, irq)
        $display("interrupt and power tests done");
        conclude();
    end
endmodule // sac_adc_control_tb_top
`default_nettype wire
